// ### verilog/pcf_pkg.sv
// shared constants and types for the pci target command filter
package pcf_pkg;

  // ----------------------------------------------------------------
  // bus command codes seen on the command/byte-enable lines
  // ----------------------------------------------------------------
  localparam logic [3:0] PCF_CMD_IO_RD = 4'h2;
  localparam logic [3:0] PCF_CMD_IO_WR = 4'h3;
  localparam logic [3:0] PCF_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PCF_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] PCF_CMD_CFG_RD = 4'ha;
  localparam logic [3:0] PCF_CMD_CFG_WR = 4'hb;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int PCF_AD_W = 32;
  localparam int PCF_BE_W = 4;
  localparam int PCF_CMD_WR_BIT = 0;
  localparam logic [1:0] PCF_CFG_TYPE0 = 2'h0;

  // ----------------------------------------------------------------
  // address space tags handed to the user side
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCF_SPACE_IO = 2'h0,
    PCF_SPACE_MEM = 2'h1,
    PCF_SPACE_CFG = 2'h2
  } pcf_space_t;

  // ----------------------------------------------------------------
  // target sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLAIM,
    ST_FETCH,
    ST_DATA,
    ST_TURN,
    ST_IGNORE
  } pcf_state_t;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic PCF_RST_N_HIGH = 1'b1;
  localparam logic [PCF_AD_W-1:0] PCF_RST_WORD = 32'h0000_0000;
  localparam logic [PCF_BE_W-1:0] PCF_RST_CBE = 4'hf;

endpackage : pcf_pkg

// ### verilog/pcf_sync.sv
// two flip-flop input synchroniser, parameterised width and reset value
`timescale 1ns/1ps
`default_nettype none

module pcf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // raw and synchronised level
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg; // first stage, read only by second stage
  logic [W-1:0] q_reg; // second stage, safe to use

  // ----------------------------------------------------------------
  // two-stage capture
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= i_d;
      q_reg <= meta_reg;
    end
  end

  assign o_q = q_reg;

endmodule : pcf_sync

`default_nettype wire

// ### verilog/pcf_target.sv
// pci target-only front end that claims io, memory and config cycles
`timescale 1ns/1ps
`default_nettype none

module pcf_target #(
  parameter int MEM_DEC_BITS = 24, // low bits inside the memory window
  parameter int IO_DEC_BITS = 8, // low bits inside the io window
  parameter logic [31:0] MEM_BASE = 32'h0000_0000,
  parameter logic [31:0] IO_BASE = 32'h0000_0000
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // pci bus inputs
  input wire logic i_pci_frame_n,
  input wire logic i_pci_irdy_n,
  input wire logic i_pci_idsel,
  input wire logic [pcf_pkg::PCF_BE_W-1:0] i_pci_cbe_n,
  input wire logic [pcf_pkg::PCF_AD_W-1:0] i_pci_ad,
  // pci bus outputs with enables
  output logic [pcf_pkg::PCF_AD_W-1:0] o_pci_ad,
  output logic o_pci_ad_oe,
  output logic o_pci_par,
  output logic o_pci_par_oe,
  output logic o_pci_devsel_n,
  output logic o_pci_trdy_n,
  output logic o_pci_stop_n,
  output logic o_pci_ctl_oe,
  // user side
  output logic o_usr_wr_valid,
  output logic o_usr_rd_req,
  output logic [pcf_pkg::PCF_AD_W-1:0] o_usr_addr,
  output logic [pcf_pkg::PCF_AD_W-1:0] o_usr_wdata,
  output logic [pcf_pkg::PCF_BE_W-1:0] o_usr_be,
  output logic [1:0] o_usr_space,
  input wire logic [pcf_pkg::PCF_AD_W-1:0] i_usr_rdata
);

  import pcf_pkg::*;

  // ----------------------------------------------------------------
  // synchronised bus inputs
  // ----------------------------------------------------------------
  logic frame_s; // frame, active low, synchronised
  logic irdy_s; // initiator ready, active low
  logic idsel_s; // config select
  logic [PCF_BE_W-1:0] cbe_s; // command / byte enables, active low
  logic [PCF_AD_W-1:0] ad_s; // address/data

  // control lines reset to their idle levels: frame and irdy high, idsel low,
  // so the frame edge detector sees no false fall after reset
  pcf_sync #(.W(3), .RST_VAL({PCF_RST_N_HIGH, PCF_RST_N_HIGH, 1'b0})) u_sync_ctl (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d({i_pci_frame_n, i_pci_irdy_n, i_pci_idsel}),
    .o_q({frame_s, irdy_s, idsel_s})
  );

  // word path; skew between bits is harmless since it is read when stable
  pcf_sync #(.W(PCF_AD_W + PCF_BE_W), .RST_VAL({PCF_RST_WORD, PCF_RST_CBE})) u_sync_ad (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d({i_pci_ad, i_pci_cbe_n}),
    .o_q({ad_s, cbe_s})
  );

  // ----------------------------------------------------------------
  // state and registered outputs
  // ----------------------------------------------------------------
  pcf_state_t state_reg, state_next; // sequencer
  logic frame_prev_reg, frame_prev_next; // frame one cycle ago, for edge
  logic wr_cyc_reg, wr_cyc_next; // current claim is a write
  logic [PCF_AD_W-1:0] ad_out_reg, ad_out_next; // read data on the bus
  logic ad_oe_reg, ad_oe_next;
  logic par_reg, par_next;
  logic par_oe_reg, par_oe_next;
  logic devsel_n_reg, devsel_n_next;
  logic trdy_n_reg, trdy_n_next;
  logic stop_n_reg, stop_n_next;
  logic ctl_oe_reg, ctl_oe_next;
  logic wr_valid_reg, wr_valid_next;
  logic rd_req_reg, rd_req_next;
  logic [PCF_AD_W-1:0] addr_reg, addr_next;
  logic [PCF_AD_W-1:0] wdata_reg, wdata_next;
  logic [PCF_BE_W-1:0] be_reg, be_next;
  logic [1:0] space_reg, space_next;

  // ----------------------------------------------------------------
  // address-phase decode
  // ----------------------------------------------------------------
  logic addr_phase; // frame has just gone active
  logic cmd_ok; // command belongs to the claimed set
  logic hit; // address falls in our decode
  pcf_space_t cmd_space; // space of the decoded command

  // decode of the command code and address window
  always_comb begin
    addr_phase = frame_prev_reg && !frame_s;
    cmd_ok = 1'b0;
    cmd_space = PCF_SPACE_IO;
    hit = 1'b0;
    unique case (cbe_s)
      PCF_CMD_IO_RD, PCF_CMD_IO_WR: begin
        cmd_ok = 1'b1;
        cmd_space = PCF_SPACE_IO;
        hit = (ad_s[PCF_AD_W-1:IO_DEC_BITS] == IO_BASE[PCF_AD_W-1:IO_DEC_BITS]);
      end
      PCF_CMD_MEM_RD, PCF_CMD_MEM_WR: begin
        cmd_ok = 1'b1;
        cmd_space = PCF_SPACE_MEM;
        hit = (ad_s[PCF_AD_W-1:MEM_DEC_BITS] == MEM_BASE[PCF_AD_W-1:MEM_DEC_BITS]);
      end
      PCF_CMD_CFG_RD, PCF_CMD_CFG_WR: begin
        cmd_ok = 1'b1;
        cmd_space = PCF_SPACE_CFG;
        hit = idsel_s && (ad_s[1:0] == PCF_CFG_TYPE0);
      end
      default: begin
        // interrupt ack, special, reserved, dual address and the
        // cache-line memory commands are all left for others
        cmd_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer next-state
  // ----------------------------------------------------------------
  // single data phase per claim: stop goes out with trdy, so a burst is
  // disconnected after one word; simpler than tracking burst addresses
  always_comb begin
    state_next = state_reg;
    frame_prev_next = frame_s;
    wr_cyc_next = wr_cyc_reg;
    ad_out_next = ad_out_reg;
    ad_oe_next = ad_oe_reg;
    par_next = ^{ad_out_reg, cbe_s}; // even parity over driven word and byte enables
    par_oe_next = ad_oe_reg; // parity trails data by one cycle
    devsel_n_next = devsel_n_reg;
    trdy_n_next = trdy_n_reg;
    stop_n_next = stop_n_reg;
    ctl_oe_next = ctl_oe_reg;
    wr_valid_next = 1'b0;
    rd_req_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    be_next = be_reg;
    space_next = space_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // only ever a target: no grant to wait on, no initiator path
        if (addr_phase) begin
          if (cmd_ok && hit) begin
            addr_next = ad_s;
            space_next = cmd_space;
            wr_cyc_next = cbe_s[PCF_CMD_WR_BIT];
            devsel_n_next = 1'b0;
            ctl_oe_next = 1'b1;
            state_next = ST_CLAIM;
          end else begin
            state_next = ST_IGNORE;
          end
        end
      end
      ST_CLAIM: begin
        if (wr_cyc_reg) begin
          trdy_n_next = 1'b0;
          stop_n_next = 1'b0;
          state_next = ST_DATA;
        end else begin
          rd_req_next = 1'b1;
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // user read data must be valid while the request is high
        ad_out_next = i_usr_rdata;
        ad_oe_next = 1'b1;
        trdy_n_next = 1'b0;
        stop_n_next = 1'b0;
        state_next = ST_DATA;
      end
      ST_DATA: begin
        if (!irdy_s) begin
          if (wr_cyc_reg) begin
            wdata_next = ad_s;
            be_next = ~cbe_s;
            wr_valid_next = 1'b1;
          end
          // drive the controls high for a cycle before letting go
          devsel_n_next = 1'b1;
          trdy_n_next = 1'b1;
          stop_n_next = 1'b1;
          ad_oe_next = 1'b0;
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        ctl_oe_next = 1'b0;
        state_next = ST_IDLE;
      end
      ST_IGNORE: begin
        // target controls stay released until the bus goes idle
        if (frame_s && irdy_s) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      frame_prev_reg <= PCF_RST_N_HIGH;
      wr_cyc_reg <= 1'b0;
      ad_out_reg <= PCF_RST_WORD;
      ad_oe_reg <= 1'b0;
      par_reg <= 1'b0;
      par_oe_reg <= 1'b0;
      devsel_n_reg <= PCF_RST_N_HIGH;
      trdy_n_reg <= PCF_RST_N_HIGH;
      stop_n_reg <= PCF_RST_N_HIGH;
      ctl_oe_reg <= 1'b0;
      wr_valid_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      addr_reg <= PCF_RST_WORD;
      wdata_reg <= PCF_RST_WORD;
      be_reg <= '0;
      space_reg <= PCF_SPACE_IO;
    end else begin
      state_reg <= state_next;
      frame_prev_reg <= frame_prev_next;
      wr_cyc_reg <= wr_cyc_next;
      ad_out_reg <= ad_out_next;
      ad_oe_reg <= ad_oe_next;
      par_reg <= par_next;
      par_oe_reg <= par_oe_next;
      devsel_n_reg <= devsel_n_next;
      trdy_n_reg <= trdy_n_next;
      stop_n_reg <= stop_n_next;
      ctl_oe_reg <= ctl_oe_next;
      wr_valid_reg <= wr_valid_next;
      rd_req_reg <= rd_req_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      be_reg <= be_next;
      space_reg <= space_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign o_pci_ad = ad_out_reg;
  assign o_pci_ad_oe = ad_oe_reg;
  assign o_pci_par = par_reg;
  assign o_pci_par_oe = par_oe_reg;
  assign o_pci_devsel_n = devsel_n_reg;
  assign o_pci_trdy_n = trdy_n_reg;
  assign o_pci_stop_n = stop_n_reg;
  assign o_pci_ctl_oe = ctl_oe_reg;
  assign o_usr_wr_valid = wr_valid_reg;
  assign o_usr_rd_req = rd_req_reg;
  assign o_usr_addr = addr_reg;
  assign o_usr_wdata = wdata_reg;
  assign o_usr_be = be_reg;
  assign o_usr_space = space_reg;

endmodule : pcf_target

`default_nettype wire

// ### sim/pcf_target_assertions.sv
// bound checker for the pci target command filter
`timescale 1ns/1ps
`default_nettype none

module pcf_target_chk #(
  parameter logic [31:0] MEM_BASE = 32'h0,
  parameter logic [31:0] IO_BASE = 32'h0
) (
  // clock, reset and bus inputs
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_pci_frame_n,
  input wire logic i_pci_idsel,
  input wire logic [3:0] i_pci_cbe_n,
  input wire logic [31:0] i_pci_ad,
  input wire logic [31:0] i_usr_rdata,
  // outputs watched
  input wire logic [31:0] o_pci_ad,
  input wire logic o_pci_ad_oe,
  input wire logic o_pci_par,
  input wire logic o_pci_par_oe,
  input wire logic o_pci_devsel_n,
  input wire logic o_pci_trdy_n,
  input wire logic o_pci_stop_n,
  input wire logic o_pci_ctl_oe,
  input wire logic o_usr_wr_valid,
  input wire logic o_usr_rd_req
);
  // ------------------------------------------------------------
  // claimable command with an address hit, as seen at the pins
  // ------------------------------------------------------------
  logic hit;
  always_comb begin
    case (i_pci_cbe_n)
      4'h2, 4'h3: hit = i_pci_ad[31:8] == IO_BASE[31:8];
      4'h6, 4'h7: hit = i_pci_ad[31:24] == MEM_BASE[31:24];
      4'ha, 4'hb: hit = i_pci_idsel && i_pci_ad[1:0] == 2'h0;
      default: hit = 1'b0;
    endcase
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // range covers the two synchroniser stages plus the claim register
  chk_claim_hit: assert property ($fell(i_pci_frame_n) && hit |-> ##[3:4] !o_pci_devsel_n)
    else $error("hit command not claimed in time");
  chk_skip_other: assert property ($fell(i_pci_frame_n) && !hit |-> ##1 !o_pci_ctl_oe [*6])
    else $error("unclaimed command drove target controls");
  chk_ctl_idle: assert property (!o_pci_ctl_oe |-> o_pci_devsel_n && o_pci_trdy_n && o_pci_stop_n && !o_pci_ad_oe)
    else $error("target control active while undriven");
  chk_ad_claimed: assert property (o_pci_ad_oe |-> !o_pci_devsel_n && !o_pci_trdy_n)
    else $error("address data driven outside a claimed read");
  chk_par_follow: assert property (o_pci_par_oe == $past(o_pci_ad_oe))
    else $error("parity enable not one cycle behind data enable");
  // parity covers last cycle's word and the command lines seen through two sync stages
  chk_par_value: assert property (o_pci_par_oe |->
    o_pci_par == ^{$past(o_pci_ad), $past(i_pci_cbe_n, 3)})
    else $error("parity bit does not match driven word");
  chk_rd_drive: assert property (o_usr_rd_req |=> o_pci_ad_oe && !o_pci_trdy_n && !o_pci_stop_n && o_pci_ad == $past(i_usr_rdata))
    else $error("read data not presented after request");
  chk_wr_pulse: assert property (o_usr_wr_valid |-> !$past(o_pci_trdy_n) && o_pci_trdy_n ##1 !o_usr_wr_valid && !o_pci_ctl_oe)
    else $error("write pulse out of place");
  chk_rd_single: assert property (o_usr_rd_req |-> !o_usr_wr_valid ##1 !o_usr_rd_req)
    else $error("read request not a single pulse");
endmodule : pcf_target_chk

bind pcf_target pcf_target_chk #(.MEM_BASE(MEM_BASE), .IO_BASE(IO_BASE)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pci_frame_n(i_pci_frame_n),
  .i_pci_idsel(i_pci_idsel), .i_pci_cbe_n(i_pci_cbe_n), .i_pci_ad(i_pci_ad),
  .i_usr_rdata(i_usr_rdata), .o_pci_ad(o_pci_ad), .o_pci_ad_oe(o_pci_ad_oe),
  .o_pci_par(o_pci_par),
  .o_pci_par_oe(o_pci_par_oe), .o_pci_devsel_n(o_pci_devsel_n), .o_pci_trdy_n(o_pci_trdy_n),
  .o_pci_stop_n(o_pci_stop_n), .o_pci_ctl_oe(o_pci_ctl_oe),
  .o_usr_wr_valid(o_usr_wr_valid), .o_usr_rd_req(o_usr_rd_req));

`default_nettype wire

// ### sim/pcf_host_model.sv
// behavioural pci initiator issuing single-word transfers
`timescale 1ns/1ps
`default_nettype none

module pcf_host_model (
  // clock and target answer
  input wire logic i_clk_sys,
  input wire logic i_devsel_n,
  input wire logic i_trdy_n,
  input wire logic [31:0] i_ad,
  // initiator drive
  output logic o_frame_n,
  output logic o_irdy_n,
  output logic o_idsel,
  output logic [3:0] o_cbe_n,
  output logic [31:0] o_ad
);
  // pulled-up controls rest high
  initial begin
    o_frame_n = 1'b1;
    o_irdy_n = 1'b1;
    o_idsel = 1'b0;
    o_cbe_n = 4'hf;
    o_ad = 32'h0;
  end

  // address phase, one data phase, master abort if nobody claims
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] be, input logic sel, output logic hit, output logic [31:0] rd);
    hit = 1'b0;
    @(negedge i_clk_sys);
    o_frame_n = 1'b0;
    o_ad = a;
    o_cbe_n = cmd;
    o_idsel = sel;
    @(negedge i_clk_sys);
    o_frame_n = 1'b1;
    o_irdy_n = 1'b0;
    o_cbe_n = ~be;
    o_idsel = 1'b0;
    // reads: released lines show the inverse, never a stale copy
    o_ad = cmd[0] ? d : ~a;
    for (int n = 0; n < 12; n++) begin
      @(posedge i_clk_sys);
      hit = hit | ~i_devsel_n;
      if (!i_trdy_n) break;
    end
    rd = i_ad;
    @(negedge i_clk_sys);
    o_irdy_n = 1'b1;
    o_cbe_n = ~o_cbe_n;
    o_ad = ~o_ad;
    repeat (6) @(negedge i_clk_sys);
  endtask : xfer
endmodule : pcf_host_model

`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the pci target command filter
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pcf_pkg::*;
  // expected user-side result of one claimed transfer
  typedef struct packed {
    logic wr;
    logic [1:0] space;
    logic [3:0] be;
    logic [31:0] addr;
    logic [31:0] data;
  } pcf_note_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic frame_n, irdy_n, idsel, ad_oe, devsel_n, trdy_n, stop_n, ctl_oe, wr_valid, rd_req;
  logic [3:0] cbe_n, u_be;
  logic [1:0] u_space;
  logic [31:0] host_ad, dut_ad, pin_ad, rdata, u_addr, u_wdata, seed;
  pcf_note_t notes[$];
  pcf_note_t got_note;
  int fail_count = 0;
  int samples_checked = 0;

  // wire levels: pull-ups on the target controls when undriven
  assign pin_ad = ad_oe ? dut_ad : host_ad;

  initial begin
    forever #50 clk = ~clk;
  end

  pcf_target dut (
    .i_clk_sys(clk), .i_rst(rst), .i_pci_frame_n(frame_n), .i_pci_irdy_n(irdy_n),
    .i_pci_idsel(idsel), .i_pci_cbe_n(cbe_n), .i_pci_ad(pin_ad), .o_pci_ad(dut_ad),
    .o_pci_ad_oe(ad_oe), .o_pci_par(), .o_pci_par_oe(), .o_pci_devsel_n(devsel_n),
    .o_pci_trdy_n(trdy_n), .o_pci_stop_n(stop_n), .o_pci_ctl_oe(ctl_oe),
    .o_usr_wr_valid(wr_valid), .o_usr_rd_req(rd_req), .o_usr_addr(u_addr),
    .o_usr_wdata(u_wdata), .o_usr_be(u_be), .o_usr_space(u_space), .i_usr_rdata(rdata));

  pcf_host_model host (
    .i_clk_sys(clk), .i_devsel_n(ctl_oe ? devsel_n : 1'b1), .i_trdy_n(ctl_oe ? trdy_n : 1'b1),
    .i_ad(pin_ad), .o_frame_n(frame_n), .o_irdy_n(irdy_n), .o_idsel(idsel),
    .o_cbe_n(cbe_n), .o_ad(host_ad));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // one transfer: note the expected user result, then run it on the bus
  task automatic run(input logic [3:0] cmd, input logic [31:0] a, input logic sel);
    logic claim, hit;
    logic [31:0] got;
    pcf_note_t n;
    seed = lfsr(seed);
    rdata = seed;
    claim = (cmd inside {PCF_CMD_IO_RD, PCF_CMD_IO_WR}) && a[31:8] == 24'h0 ||
      (cmd inside {PCF_CMD_MEM_RD, PCF_CMD_MEM_WR}) && a[31:24] == 8'h0 ||
      (cmd inside {PCF_CMD_CFG_RD, PCF_CMD_CFG_WR}) && sel && a[1:0] == 2'h0;
    n = {cmd[PCF_CMD_WR_BIT], cmd[3] ? PCF_SPACE_CFG : cmd[2] ? PCF_SPACE_MEM : PCF_SPACE_IO,
      seed[7:4], a, ~seed};
    if (claim) notes.push_back(n);
    host.xfer(cmd, a, ~seed, seed[7:4], sel, hit, got);
    chk({31'h0, hit}, {31'h0, claim});
    if (claim && !n.wr) chk(got, seed);
  endtask : run

  // user-side monitor takes the oldest note on every pulse, mid-cycle when settled
  always @(negedge clk) begin
    if (wr_valid === 1'b1 || rd_req === 1'b1) begin
      // exactly one transfer is in flight, so a pulse must find one note
      chk(notes.size(), 32'h1);
      if (notes.size() > 0) begin
        got_note = notes.pop_front();
        chk({29'h0, u_space, wr_valid}, {29'h0, got_note.space, got_note.wr});
        chk(u_addr, got_note.addr);
        if (got_note.wr) chk({28'h0, u_be}, {28'h0, got_note.be});
        if (got_note.wr) chk(u_wdata, got_note.data);
      end
    end
  end

  initial begin
    rdata = 32'h0;
    seed = 32'h21;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    // every command code with a hitting address
    for (int c = 0; c < 16; c++) run(c[3:0], {24'h0, seed[7:2], 2'h0}, 1'b1);
    // address misses, unselected and non type-0 configuration
    for (int k = 0; k < 4; k++) run({k[1], 2'h1, k[0]}, {8'h5a, seed[23:0]}, 1'b0);
    run(PCF_CMD_CFG_WR, 32'h1, 1'b1);
    run(PCF_CMD_CFG_RD, 32'h4, 1'b0);
    // random traffic
    for (int k = 0; k < 24; k++) run(seed[3:0], {seed[31] ? 8'h0 : 8'h3c, seed[23:0]}, seed[9]);
    chk(notes.size(), 32'h0);
    close_out();
  end
endmodule : tb_top

`default_nettype wire
